/* File: src/clock_gen_smbus_config_regs.sv */
// smbus slave with configuration registers and output mode decode
`timescale 1ns/10ps
`default_nettype none
module clock_gen_smbus_config_regs #(
  // arbitrary value
  parameter logic [4:0] DEVICE_REV = 5'h01,
  // arbitrary value
  parameter logic [2:0] VENDOR_CODE = 3'h5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_strap0,
  input wire logic addr_strap1,
  input wire logic outputs_enable_in,
  input wire logic bypass_n_in,
  output logic [2:0] pll_factor_sel,
  output logic ref_freq_choice,
  output logic vendor_test_select,
  output logic [3:0] out_drive_en,
  output logic out_src_ref
);
  import clkgen_cfg_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } link_state_t;

  // pin synchronisation
  logic [SYNC_WIDTH-1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic strap0_s;
  logic strap1_s;
  logic en_s;
  logic bypass_n_s;

  pin_sync2 #(
    .WIDTH(SYNC_WIDTH),
    .RST_VAL(6'h3F)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({scl_in, sda_in, addr_strap1, addr_strap0, outputs_enable_in, bypass_n_in}),
    .q(pins_s)
  );

  assign scl_s = pins_s[5];
  assign sda_s = pins_s[4];
  assign strap1_s = pins_s[3];
  assign strap0_s = pins_s[2];
  assign en_s = pins_s[1];
  assign bypass_n_s = pins_s[0];

  // edge detection on the synchronised link
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_cond = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_cond = scl_s && scl_d_r && !sda_d_r && sda_s;

  // strap capture after reset release
  logic [1:0] strap_cnt_r;
  logic [1:0] strap_cnt_nxt;
  logic [1:0] straps_r;
  logic [1:0] straps_nxt;

  // link and register state
  link_state_t state_r;
  link_state_t state_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [1:0] byte_idx_r;
  logic [1:0] byte_idx_nxt;
  logic rw_r;
  logic rw_nxt;
  logic mack_r;
  logic mack_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [7:0] pll_out_r;
  logic [7:0] pll_out_nxt;
  logic [7:0] ref_test_r;
  logic [7:0] ref_test_nxt;
  logic sda_oe_n_r;
  logic sda_oe_n_nxt;

  // output mode
  logic [3:0] drive_en_r;
  logic [3:0] drive_en_nxt;
  logic src_ref_r;
  logic src_ref_nxt;

  // register read mux; unknown codes read as zero
  function automatic logic [7:0] reg_read(input logic [7:0] code, input logic [7:0] a,
                                          input logic [7:0] b);
    logic [7:0] v;
    v = 8'h00;
    unique case (code)
      CMD_PLL_OUT: v = a;
      CMD_REF_TEST: v = b;
      CMD_IDENT: v = {DEVICE_REV, VENDOR_CODE};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    strap_cnt_nxt = strap_cnt_r;
    straps_nxt = straps_r;
    // straps settle through the synchroniser before capture
    if (strap_cnt_r != STRAP_SETTLE) begin
      strap_cnt_nxt = strap_cnt_r + 2'h1;
      if (strap_cnt_r == (STRAP_SETTLE - 2'h1)) begin
        straps_nxt = {strap1_s, strap0_s};
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    byte_idx_nxt = byte_idx_r;
    rw_nxt = rw_r;
    mack_nxt = mack_r;
    ptr_nxt = ptr_r;
    pll_out_nxt = pll_out_r;
    ref_test_nxt = ref_test_r;
    sda_oe_n_nxt = sda_oe_n_r;
    // no bus timeout: a stalled clock simply holds the state
    if (stop_cond) begin
      state_nxt = ST_IDLE;
      sda_oe_n_nxt = 1'b1;
    end else if (start_cond) begin
      // repeated start keeps ptr_r for the read phase
      state_nxt = ST_RX;
      bit_cnt_nxt = 4'h0;
      byte_idx_nxt = 2'h0;
      sda_oe_n_nxt = 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          sda_oe_n_nxt = 1'b1;
        end
        ST_RX: begin
          if (scl_rise && bit_cnt_r != BITS_PER_BYTE) begin
            shift_nxt = {shift_r[6:0], sda_s};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
            bit_cnt_nxt = 4'h0;
            state_nxt = ST_RX_ACK;
            sda_oe_n_nxt = 1'b0;
            if (byte_idx_r == 2'h0) begin
              // foreign address: stay silent until the next start
              if (shift_r[7:3] != SLAVE_ADDR_UPPER || shift_r[2:1] != straps_r) begin
                state_nxt = ST_IDLE;
                sda_oe_n_nxt = 1'b1;
              end
              rw_nxt = shift_r[0];
            end else if (byte_idx_r == 2'h1) begin
              ptr_nxt = shift_r;
            end else begin
              // second word byte lands on the next code
              ptr_nxt = ptr_r + 8'h01;
              if (ptr_r == CMD_PLL_OUT) begin
                pll_out_nxt = shift_r;
              end else if (ptr_r == CMD_REF_TEST) begin
                ref_test_nxt = shift_r;
              end
            end
            if (byte_idx_r != 2'h2) begin
              byte_idx_nxt = byte_idx_r + 2'h1;
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            if (byte_idx_r == 2'h1 && rw_r) begin
              shift_nxt = reg_read(ptr_r, pll_out_r, ref_test_r);
              ptr_nxt = ptr_r + 8'h01;
              sda_oe_n_nxt = reg_read(ptr_r, pll_out_r, ref_test_r) >> 7 != 8'h00;
              state_nxt = ST_TX;
            end else begin
              sda_oe_n_nxt = 1'b1;
              state_nxt = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == (BITS_PER_BYTE - 4'h1)) begin
              bit_cnt_nxt = 4'h0;
              sda_oe_n_nxt = 1'b1;
              state_nxt = ST_TX_ACK;
            end else begin
              bit_cnt_nxt = bit_cnt_r + 4'h1;
              shift_nxt = {shift_r[6:0], 1'b0};
              sda_oe_n_nxt = shift_r[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            mack_nxt = !sda_s;
          end else if (scl_fall) begin
            // master ack asks for the word's second byte
            if (mack_r) begin
              shift_nxt = reg_read(ptr_r, pll_out_r, ref_test_r);
              ptr_nxt = ptr_r + 8'h01;
              sda_oe_n_nxt = reg_read(ptr_r, pll_out_r, ref_test_r) >> 7 != 8'h00;
              state_nxt = ST_TX;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // pin mode decode, one cycle behind the sampled pins
  always_comb begin
    drive_en_nxt = 4'h0;
    src_ref_nxt = 1'b0;
    if (en_s && !ref_test_r[TEST_SEL_BIT]) begin
      if (!bypass_n_s) begin
        drive_en_nxt = 4'hF;
        src_ref_nxt = 1'b1;
      end else begin
        drive_en_nxt[0] = pll_out_r[OUT0_SEL_BIT];
        drive_en_nxt[1] = pll_out_r[OUT1_SEL_BIT];
        drive_en_nxt[2] = pll_out_r[OUT2_SEL_BIT];
        drive_en_nxt[3] = pll_out_r[OUT3_SEL_BIT];
      end
    end
    // test mode is vendor reserved; outputs stay off there
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      strap_cnt_r <= 2'h0;
      straps_r <= 2'h0;
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      byte_idx_r <= 2'h0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      ptr_r <= 8'h00;
      pll_out_r <= POD_PLL_OUT;
      ref_test_r <= POD_REF_TEST;
      sda_oe_n_r <= 1'b1;
      drive_en_r <= 4'h0;
      src_ref_r <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      strap_cnt_r <= strap_cnt_nxt;
      straps_r <= straps_nxt;
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      byte_idx_r <= byte_idx_nxt;
      rw_r <= rw_nxt;
      mack_r <= mack_nxt;
      ptr_r <= ptr_nxt;
      pll_out_r <= pll_out_nxt;
      ref_test_r <= ref_test_nxt;
      sda_oe_n_r <= sda_oe_n_nxt;
      drive_en_r <= drive_en_nxt;
      src_ref_r <= src_ref_nxt;
    end
  end

  // open drain: the pin only ever pulls low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      pll_factor_sel <= POD_PLL_OUT[PLL_FACTOR_MSB:PLL_FACTOR_LSB];
      ref_freq_choice <= POD_REF_TEST[REF_FREQ_BIT];
      vendor_test_select <= POD_REF_TEST[TEST_SEL_BIT];
      out_drive_en <= 4'h0;
      out_src_ref <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n <= sda_oe_n_r;
      pll_factor_sel <= pll_out_r[PLL_FACTOR_MSB:PLL_FACTOR_LSB];
      ref_freq_choice <= ref_test_r[REF_FREQ_BIT];
      vendor_test_select <= ref_test_r[TEST_SEL_BIT];
      out_drive_en <= drive_en_r;
      out_src_ref <= src_ref_r;
    end
  end

endmodule // clock_gen_smbus_config_regs
`default_nettype wire

/* File: src/clkgen_cfg_pkg.sv */
// constants shared by the serial configuration register bank
// Functional notes
// - pll factor field bits 6:4, defaults 001
// - bits 3:0 select outputs 0..3, default one
// - spare storage bits, no effect, default zero
// - reference frequency choice bit, default zero
// - bit 3 defaults one; host keeps writing one
// - bits 1:0 default zero; bit 0 test
// - revision number read only, writes ignored
// - vendor code fixed, read only
// - power-on defaults loaded before any access
// - smbus slave, byte and word transfers
// - slave address holds two strap pins
// - no timeout detection, no packet error check
// - enable high, bypass low, test clear: reference drives outputs
package clkgen_cfg_pkg;

  // command codes
  localparam logic [7:0] CMD_PLL_OUT = 8'h80;
  localparam logic [7:0] CMD_REF_TEST = 8'h81;
  localparam logic [7:0] CMD_IDENT = 8'h82;

  // power-on defaults
  localparam logic [7:0] POD_PLL_OUT = 8'h1F;
  localparam logic [7:0] POD_REF_TEST = 8'h08;

  // field positions in pll_and_output_select
  localparam int PLL_FACTOR_MSB = 6;
  localparam int PLL_FACTOR_LSB = 4;
  localparam int OUT0_SEL_BIT = 3;
  localparam int OUT1_SEL_BIT = 2;
  localparam int OUT2_SEL_BIT = 1;
  localparam int OUT3_SEL_BIT = 0;

  // field positions in reference_and_test_control
  localparam int MUST_ONE_BIT = 3;
  localparam int REF_FREQ_BIT = 2;
  localparam int TEST_SEL_BIT = 0;

  // field positions in revision_and_vendor_ident
  localparam int REV_MSB = 7;
  localparam int REV_LSB = 3;
  localparam int VENDOR_MSB = 2;

  // slave address: five fixed upper bits, two straps, read/write
  localparam logic [4:0] SLAVE_ADDR_UPPER = 5'h1B;

  // bits per byte on the serial link
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // cycles after reset release before the straps are caught
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // number of synchronised pins
  localparam int SYNC_WIDTH = 6;

endpackage

/* File: src/pin_sync2.sv */
// two flip-flop synchroniser for a group of pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // meta_r feeds q only, never other logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // pin_sync2
`default_nettype wire

/* File: bench/clock_gen_smbus_config_regs_checker.sv */
// port assertions for the configuration bank
`timescale 1ns/10ps
`default_nettype none
module clock_gen_smbus_config_regs_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_oe_n,
  input wire logic outputs_enable_in,
  input wire logic bypass_n_in,
  input wire logic [2:0] pll_factor_sel,
  input wire logic ref_freq_choice,
  input wire logic vendor_test_select,
  input wire logic [3:0] out_drive_en,
  input wire logic out_src_ref
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_pod;
    $rose(rst_n) |-> pll_factor_sel == 3'h1 && !ref_freq_choice && !vendor_test_select;
  endproperty
  a_pod: assert property (p_pod) else $error("bad default");
  property p_en_off;
    !outputs_enable_in [*8] |-> out_drive_en == 4'h0;
  endproperty
  a_en_off: assert property (p_en_off) else $error("drive while off");
  property p_bypass;
    (outputs_enable_in && !bypass_n_in && !vendor_test_select) [*8]
      |-> out_drive_en == 4'hF && out_src_ref;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong");
  property p_test_off;
    (outputs_enable_in && vendor_test_select) [*8] |-> out_drive_en == 4'h0;
  endproperty
  a_test_off: assert property (p_test_off) else $error("test drive");
  property p_no_ref;
    bypass_n_in [*8] |-> !out_src_ref;
  endproperty
  a_no_ref: assert property (p_no_ref) else $error("ref source");
  // registers only move inside a write, while the clock line is low
  property p_reg_quiet;
    !$stable({pll_factor_sel, ref_freq_choice, vendor_test_select}) |-> !scl_in;
  endproperty
  a_reg_quiet: assert property (p_reg_quiet) else $error("late update");
  property p_sda_edge;
    !$stable(sda_oe_n) |-> !scl_in;
  endproperty
  a_sda_edge: assert property (p_sda_edge) else $error("sda moved");
  property p_ack_len;
    $fell(sda_oe_n) |-> ##[1:400] sda_oe_n;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("sda stuck");
  c_ack: cover property ($fell(sda_oe_n));
  c_wr: cover property ($changed(pll_factor_sel));
  c_byp: cover property ($rose(out_src_ref));
endmodule // clock_gen_smbus_config_regs_checker
bind clock_gen_smbus_config_regs clock_gen_smbus_config_regs_checker
  clock_gen_smbus_config_regs_checker_inst (.clk(clk), .rst_n(rst_n), .scl_in(scl_in),
  .sda_oe_n(sda_oe_n), .outputs_enable_in(outputs_enable_in), .bypass_n_in(bypass_n_in),
  .pll_factor_sel(pll_factor_sel), .ref_freq_choice(ref_freq_choice),
  .vendor_test_select(vendor_test_select), .out_drive_en(out_drive_en),
  .out_src_ref(out_src_ref));
`default_nettype wire

/* File: bench/smbus_host_model.sv */
// behavioural smbus host, 125 ns clock, idle high
`timescale 1ns/10ps
`default_nettype none
module smbus_host_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data set mid-low, sampled late in the high phase
  task automatic bit_io(input logic o, output logic i);
    sda_rel <= o;
    wt(6);
    scl <= 1'b1;
    wt(12);
    i = sda_line;
    scl <= 1'b0;
    wt(7);
  endtask
  task automatic start;
    sda_rel <= 1'b1;
    wt(6);
    scl <= 1'b1;
    wt(6);
    sda_rel <= 1'b0;
    wt(6);
    scl <= 1'b0;
    wt(7);
  endtask
  task automatic stop;
    sda_rel <= 1'b0;
    wt(6);
    scl <= 1'b1;
    wt(6);
    sda_rel <= 1'b1;
    wt(12);
  endtask
  // plain bytes only, no packet error byte
  task automatic wr_byte(input logic [7:0] b, output logic ack_n);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(b[i], x);
    bit_io(1'b1, ack_n);
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, x);
  endtask
endmodule // smbus_host_model
`default_nettype wire

/* File: bench/clock_gen_smbus_config_regs_test.sv */
// self-checking bench for the configuration register bank
`timescale 1ns/10ps
`default_nettype none
`define HOST smbus_host_model_inst
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module clock_gen_smbus_config_regs_test;
  import clkgen_cfg_pkg::*;
  // arbitrary identity values
  localparam logic [4:0] REV = 5'h03;
  localparam logic [2:0] VEND = 3'h6;
  typedef logic [23:0] row_t;
  // command, written, read back; host keeps the fixed bits of 0x81
  row_t rows [6] = '{24'h80A1A1, 24'h800E0E, 24'h81F8F8, 24'h810C0C,
    {16'h8200, REV, VEND}, 24'h45AA00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  logic byp_n = 1'b1;
  logic strap0 = 1'b1;
  logic strap1 = 1'b0;
  logic [7:0] dev = 8'hDA;
  logic scl, rel, sda_line, sda_out, sda_oe_n, ref_ch, tst, src_ref, k;
  logic [2:0] pll;
  logic [3:0] drv;
  logic [7:0] s80 = POD_PLL_OUT;
  logic [7:0] s81 = POD_REF_TEST;
  logic [15:0] d;
  int error_cnt = 0;
  int num_checks = 0;
  assign sda_line = rel & (sda_oe_n | sda_out);
  always #2.5 clk = ~clk;
  clock_gen_smbus_config_regs #(.DEVICE_REV(REV), .VENDOR_CODE(VEND))
    clock_gen_smbus_config_regs_inst (.clk(clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap0(strap0),
    .addr_strap1(strap1), .outputs_enable_in(en), .bypass_n_in(byp_n),
    .pll_factor_sel(pll), .ref_freq_choice(ref_ch), .vendor_test_select(tst),
    .out_drive_en(drv), .out_src_ref(src_ref));
  smbus_host_model smbus_host_model_inst (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_rel(rel));
  task automatic complete_run;
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic bus_wr(input logic [7:0] a, c, input logic [15:0] v, input int n);
    logic x;
    `HOST.start();
    `HOST.wr_byte(a, k);
    `HOST.wr_byte(c, x);
    for (int i = 0; i < n; i++) `HOST.wr_byte(v[8*i+:8], x);
    `HOST.stop();
  endtask
  task automatic bus_rd(input logic [7:0] c, input int n);
    logic x;
    d = 16'h0000;
    `HOST.start();
    `HOST.wr_byte(dev, x);
    `HOST.wr_byte(c, x);
    `HOST.start();
    `HOST.wr_byte(dev | 8'h01, x);
    for (int i = 0; i < n; i++) `HOST.rd_byte(i == n - 1, d[8*i+:8]);
    `HOST.stop();
  endtask
  task automatic outs;
    `HOST.wt(4);
    `CHK("pll", s80[6:4], pll)
    `CHK("ref", s81[2], ref_ch)
    `CHK("test", s81[0], tst)
    `CHK("drive", {s80[0], s80[1], s80[2], s80[3]}, drv)
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    `HOST.wt(20);
    foreach (rows[i]) begin
      bus_wr(8'hDA, rows[i][23:16], {8'h00, rows[i][15:8]}, 1);
      bus_rd(rows[i][23:16], 1);
      if (rows[i][23:16] == CMD_PLL_OUT) s80 = rows[i][7:0];
      if (rows[i][23:16] == CMD_REF_TEST) s81 = rows[i][7:0];
      `CHK("ack", 1'b0, k)
      `CHK("read", rows[i][7:0], d[7:0])
      outs();
    end
    bus_wr(8'hDA, CMD_PLL_OUT, 16'h0C35, 2);
    bus_rd(CMD_PLL_OUT, 2);
    s80 = 8'h35;
    s81 = 8'h0C;
    `CHK("word", 16'h0C35, d)
    outs();
    bus_wr(8'hD8, CMD_PLL_OUT, 16'h0000, 1);
    bus_rd(CMD_PLL_OUT, 1);
    `CHK("nack", 1'b1, k)
    `CHK("kept", 8'h35, d[7:0])
    bus_wr(8'hDA, CMD_REF_TEST, 16'h0009, 1);
    `HOST.wt(10);
    `CHK("test off", 4'h0, drv)
    bus_wr(8'hDA, CMD_REF_TEST, 16'h0008, 1);
    byp_n <= 1'b0;
    `HOST.wt(10);
    `CHK("bypass", 5'h1F, {src_ref, drv})
    byp_n <= 1'b1;
    en <= 1'b0;
    `HOST.wt(10);
    `CHK("disabled", 4'h0, drv)
    en <= 1'b1;
    rst_n <= 1'b0;
    // straps are only caught after a reset release
    strap0 <= 1'b0;
    strap1 <= 1'b1;
    `HOST.wt(5);
    rst_n <= 1'b1;
    `HOST.wt(20);
    bus_wr(8'hDA, CMD_PLL_OUT, 16'h0000, 1);
    `CHK("old addr", 1'b1, k)
    dev = 8'hDC;
    bus_rd(CMD_PLL_OUT, 2);
    `CHK("defaults", {POD_REF_TEST, POD_PLL_OUT}, d)
    s80 = POD_PLL_OUT;
    s81 = POD_REF_TEST;
    outs();
    complete_run();
  end
  // a hung bus cuts the run short
  initial begin
    `HOST.wt(60000);
    error_cnt++;
    complete_run();
  end
endmodule // clock_gen_smbus_config_regs_test
`default_nettype wire
